// *** design/rdr_unit.sv ***
// Rotate and BCD digit rotate datapath with flag update
`timescale 1ns/100ps
module rdr_unit #(
  parameter int WORD_W = rdr_pkg::WORD_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Request from decoder
  input wire logic req_valid,
  input wire logic [rdr_pkg::OP_W-1:0] req_op,
  input wire logic req_byte,
  input wire logic req_twice,
  input wire logic [rdr_pkg::WORD_W-1:0] req_dst,
  input wire logic [rdr_pkg::BYTE_W-1:0] req_src,
  // Flags in
  input wire logic req_carry,
  input wire logic req_zero,
  input wire logic req_sign,
  input wire logic req_ovf,
  input wire logic req_dec,
  input wire logic req_half,
  // Status
  output logic busy,
  // Result to register file
  output logic res_valid,
  output logic [rdr_pkg::WORD_W-1:0] res_dst,
  output logic [rdr_pkg::BYTE_W-1:0] res_src,
  // Flags out
  output logic res_carry,
  output logic res_zero,
  output logic res_sign,
  output logic res_ovf,
  output logic res_dec,
  output logic res_half
);
  // The byte and nibble split below is wired for this one operand shape
  if (WORD_W != rdr_pkg::WORD_W) begin : g_bad_width
    $error("rdr_unit supports only a 16-bit word");
  end
  if (rdr_pkg::BYTE_W != rdr_pkg::BYTE_MSB + 1) begin : g_bad_byte
    $error("rdr_unit byte width and byte top bit disagree");
  end
  if (rdr_pkg::WORD_W != rdr_pkg::WORD_MSB + 1) begin : g_bad_word
    $error("rdr_unit word width and word top bit disagree");
  end
  if (rdr_pkg::NIB_HI_BOT != rdr_pkg::NIB_LO_TOP + 1) begin : g_bad_nibble
    $error("rdr_unit nibbles must be adjacent");
  end

  typedef struct packed {
    rdr_pkg::rdr_fsm_t fsm;
    logic [rdr_pkg::OP_W-1:0] op;
    logic byte_m;
    logic second;
    logic [rdr_pkg::WORD_W-1:0] val;
    logic [rdr_pkg::BYTE_W-1:0] src;
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic busy;
    logic valid;
  } rdr_state_t;

  // Reset image of the whole state
  localparam rdr_state_t ST_RESET = '{
    fsm: rdr_pkg::RDR_IDLE,
    op: rdr_pkg::OP_WORD_ROTATE_LEFT,
    byte_m: 1'b0,
    second: 1'b0,
    val: rdr_pkg::DST_RESET,
    src: rdr_pkg::SRC_RESET,
    c: 1'b0,
    z: 1'b0,
    s: 1'b0,
    v: 1'b0,
    d: 1'b0,
    h: 1'b0,
    busy: 1'b0,
    valid: 1'b0
  };

  rdr_state_t st_q;
  rdr_state_t st_d;
  logic [rdr_pkg::WORD_W-1:0] step_val;
  logic step_c;
  logic step_v;
  logic req_bit_op;
  logic req_digit_op;
  logic legal;
  logic digit;
  logic [rdr_pkg::NIB_LO_TOP:0] dl;
  logic [rdr_pkg::NIB_LO_TOP:0] sl;
  logic [rdr_pkg::NIB_LO_TOP:0] sh;

  // One shared step; a two-position rotate iterates it
  rdr_step u_step (
    .op(st_q.op),
    .byte_mode(st_q.byte_m),
    .val(st_q.val),
    .carry(st_q.c),
    .val_n(step_val),
    .carry_n(step_c),
    .ovf_n(step_v)
  );

  // Codes past the last digit rotate are refused outright
  assign req_bit_op = (req_op == rdr_pkg::OP_WORD_ROTATE_LEFT) || (req_op == rdr_pkg::OP_WORD_ROTATE_RIGHT) ||
    (req_op == rdr_pkg::OP_ROTATE_LEFT_THROUGH_CARRY) || (req_op == rdr_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY);
  assign req_digit_op = (req_op == rdr_pkg::OP_BCD_DIGIT_ROTATE_LEFT) ||
    (req_op == rdr_pkg::OP_BCD_DIGIT_ROTATE_RIGHT);
  assign legal = req_bit_op || req_digit_op;
  assign digit = (st_q.op == rdr_pkg::OP_BCD_DIGIT_ROTATE_LEFT) || (st_q.op == rdr_pkg::OP_BCD_DIGIT_ROTATE_RIGHT);
  assign dl = st_q.val[rdr_pkg::NIB_LO_TOP:0];
  assign sl = st_q.src[rdr_pkg::NIB_LO_TOP:0];
  assign sh = st_q.src[rdr_pkg::BYTE_MSB:rdr_pkg::NIB_HI_BOT];

  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    unique case (st_q.fsm)
      rdr_pkg::RDR_IDLE: begin
        // Requests while busy are never looked at
        if (req_valid && legal) begin
          st_d.fsm = rdr_pkg::RDR_RUN;
          st_d.busy = 1'b1;
          st_d.op = req_op;
          // Digit rotates are byte operations whatever the decoder says
          st_d.byte_m = req_byte || req_digit_op;
          st_d.second = req_twice;
          st_d.val = req_dst;
          st_d.src = req_src;
          st_d.c = req_carry;
          st_d.z = req_zero;
          st_d.s = req_sign;
          st_d.v = req_ovf;
          st_d.d = req_dec;
          st_d.h = req_half;
        end
      end
      rdr_pkg::RDR_RUN: begin
        if (digit) begin
          // Distinct registers assumed; one register for both is undefined
          if (st_q.op == rdr_pkg::OP_BCD_DIGIT_ROTATE_LEFT) begin
            st_d.src = {sl, dl};
            st_d.val[rdr_pkg::NIB_LO_TOP:0] = sh;
          end else begin
            st_d.src = {dl, sh};
            st_d.val[rdr_pkg::NIB_LO_TOP:0] = sl;
          end
          st_d.fsm = rdr_pkg::RDR_HOLD;
        end else begin
          st_d.val = step_val;
          st_d.c = step_c;
          st_d.v = step_v;
          if (st_q.second) begin
            st_d.second = 1'b0;
          end else begin
            st_d.fsm = rdr_pkg::RDR_HOLD;
          end
        end
      end
      rdr_pkg::RDR_HOLD: begin
        // Flags from the final destination only
        st_d.z = st_q.byte_m ? (st_q.val[rdr_pkg::BYTE_MSB:0] == 8'h00) : (st_q.val == 16'h0000);
        st_d.s = st_q.byte_m ? st_q.val[rdr_pkg::BYTE_MSB] : st_q.val[rdr_pkg::WORD_MSB];
        st_d.valid = 1'b1;
        st_d.busy = 1'b0;
        st_d.fsm = rdr_pkg::RDR_IDLE;
      end
      default: begin
        st_d.fsm = rdr_pkg::RDR_IDLE;
        st_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
  assign res_valid = st_q.valid;
  assign res_dst = st_q.val;
  assign res_src = st_q.src;
  // Carry and overflow of a digit rotate are the inputs passed back
  assign res_carry = st_q.c;
  assign res_zero = st_q.z;
  assign res_sign = st_q.s;
  assign res_ovf = st_q.v;
  assign res_dec = st_q.d;
  assign res_half = st_q.h;
endmodule

// *** inc/rdr_pkg.sv ***
// Constants and types shared by the rotate and digit rotate unit
// Behaviour
// - Word or byte rotate left, one or two
// - Word or byte rotate right, one or two
// - Count bit: zero one step, one two
// - Rotate left: top bit to bit0 and carry
// - Left through carry: top to carry, carry to bit0
// - Rotate right: bit0 to top and carry
// - Right through carry: bit0 to carry, carry top
// - Left rotate carry equals last top bit out
// - Right rotate carry equals last bit0 out
// - Zero flag set when final destination zero
// - Sign flag equals final destination top bit
// - Bit rotates: overflow when the last step changed the sign bit
// - Digit rotates treat bytes as nibble pairs
// - Left digit: dl to sl, sl to sh, sh to dl
// - Right digit: dl to sh, sh to sl, sl to dl
// - Digit rotates keep destination high nibble
package rdr_pkg;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int WORD_MSB = 15;
  localparam int BYTE_MSB = 7;
  localparam int NIB_LO_TOP = 3;
  localparam int NIB_HI_BOT = 4;
  localparam int OP_W = 3;
  localparam logic [OP_W-1:0] OP_WORD_ROTATE_LEFT = 3'h0;
  localparam logic [OP_W-1:0] OP_WORD_ROTATE_RIGHT = 3'h1;
  localparam logic [OP_W-1:0] OP_ROTATE_LEFT_THROUGH_CARRY = 3'h2;
  localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 3'h3;
  localparam logic [OP_W-1:0] OP_BCD_DIGIT_ROTATE_LEFT = 3'h4;
  localparam logic [OP_W-1:0] OP_BCD_DIGIT_ROTATE_RIGHT = 3'h5;
  localparam logic [WORD_W-1:0] DST_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] SRC_RESET = 8'h00;

  typedef enum logic [2:0] {
    RDR_IDLE = 3'h1,
    RDR_RUN = 3'h2,
    RDR_HOLD = 3'h4
  } rdr_fsm_t;
endpackage

// *** design/rdr_step.sv ***
// One single-position bit rotate step for word or byte operands
`timescale 1ns/100ps
module rdr_step (
  // Operation select
  input wire logic [rdr_pkg::OP_W-1:0] op,
  input wire logic byte_mode,
  // Operand in
  input wire logic [rdr_pkg::WORD_W-1:0] val,
  input wire logic carry,
  // Operand out
  output logic [rdr_pkg::WORD_W-1:0] val_n,
  output logic carry_n,
  output logic ovf_n
);
  logic top_old;
  logic top_new;

  always_comb begin
    val_n = val;
    carry_n = carry;
    top_old = byte_mode ? val[rdr_pkg::BYTE_MSB] : val[rdr_pkg::WORD_MSB];
    unique case (op)
      rdr_pkg::OP_WORD_ROTATE_LEFT, rdr_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
        // Left: operand bits move up (low byte only in byte mode), bit0 fed from top or old carry
        carry_n = top_old;
        if (byte_mode) begin
          val_n[rdr_pkg::BYTE_MSB:1] = val[rdr_pkg::BYTE_MSB-1:0];
        end else begin
          val_n[rdr_pkg::WORD_MSB:1] = val[rdr_pkg::WORD_MSB-1:0];
        end
        val_n[0] = (op == rdr_pkg::OP_WORD_ROTATE_LEFT) ? top_old : carry;
      end
      rdr_pkg::OP_WORD_ROTATE_RIGHT, rdr_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        carry_n = val[0];
        if (byte_mode) begin
          val_n[rdr_pkg::BYTE_MSB-1:0] = val[rdr_pkg::BYTE_MSB:1];
          val_n[rdr_pkg::BYTE_MSB] = (op == rdr_pkg::OP_WORD_ROTATE_RIGHT) ? val[0] : carry;
        end else begin
          val_n[rdr_pkg::WORD_MSB-1:0] = val[rdr_pkg::WORD_MSB:1];
          val_n[rdr_pkg::WORD_MSB] = (op == rdr_pkg::OP_WORD_ROTATE_RIGHT) ? val[0] : carry;
        end
      end
      default: begin
        val_n = val;
      end
    endcase
    top_new = byte_mode ? val_n[rdr_pkg::BYTE_MSB] : val_n[rdr_pkg::WORD_MSB];
    ovf_n = top_old ^ top_new;
  end
endmodule

// *** dv/rdr_unit_chk.sv ***
// Port assertions for the rotate unit
`timescale 1ns/100ps
module rdr_unit_chk #(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Request
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic req_byte,
  input wire logic req_twice,
  input wire logic [WORD_W-1:0] req_dst,
  input wire logic [7:0] req_src,
  input wire logic req_carry,
  input wire logic req_ovf,
  input wire logic req_dec,
  input wire logic req_half,
  // Result
  input wire logic busy,
  input wire logic res_valid,
  input wire logic [WORD_W-1:0] res_dst,
  input wire logic [7:0] res_src,
  input wire logic res_carry,
  input wire logic res_zero,
  input wire logic res_sign,
  input wire logic res_ovf,
  input wire logic res_dec,
  input wire logic res_half
);
  logic acc, bm, c, v, d, h, nb;
  logic [2:0] op;
  logic [15:0] ds;
  logic [7:0] sr;
  assign acc = req_valid && !busy && req_op <= 3'h5;
  // Digit ops always work on bytes
  assign nb = bm | op[2];
  always_ff @(posedge clock) begin
    if (acc) begin
      {op, bm, ds, sr} <= {req_op, req_byte, req_dst, req_src};
      {c, v, d, h} <= {req_carry, req_ovf, req_dec, req_half};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_one_step_time: assert property (acc && !(req_twice && !req_op[2]) |=> busy[*2] ##1 res_valid)
    else $error("single step result late");
  a_two_step_time: assert property (acc && req_twice && !req_op[2] |=> busy[*3] ##1 res_valid)
    else $error("two step result late");
  a_zero_flag: assert property (res_valid |-> res_zero == (nb ? res_dst[7:0] == 8'h00 : res_dst == 16'h0000))
    else $error("zero flag wrong");
  a_sign_flag: assert property (res_valid |-> res_sign == (nb ? res_dst[7] : res_dst[15]))
    else $error("sign flag wrong");
  a_flags_kept: assert property (res_valid |-> res_dec == d && res_half == h)
    else $error("decimal or half flag changed");
  a_digit_cv_kept: assert property (res_valid && op[2] |-> res_carry == c && res_ovf == v)
    else $error("digit op changed carry or overflow");
  a_digit_left: assert property (res_valid && op == 3'h4 |-> res_dst == {ds[15:4], sr[7:4]} && res_src == {sr[3:0], ds[3:0]})
    else $error("left digit rotate wrong");
  a_digit_right: assert property (res_valid && op == 3'h5 |-> res_dst == {ds[15:4], sr[3:0]} && res_src == {ds[3:0], sr[7:4]})
    else $error("right digit rotate wrong");
  a_bit_keep_rest: assert property (res_valid && !op[2] |-> res_src == sr && (!bm || res_dst[15:8] == ds[15:8]))
    else $error("bit rotate touched unused bits");
endmodule

bind rdr_unit rdr_unit_chk #(.WORD_W(WORD_W)) chk (.clock, .resetn, .req_valid, .req_byte, .req_twice,
  .req_carry, .req_ovf, .req_dec, .req_half, .busy, .res_valid, .res_zero, .res_sign, .res_carry, .res_ovf,
  .res_dec, .res_half, .req_op, .req_dst, .res_dst, .req_src, .res_src);

// *** dv/rdr_dec_model.sv ***
// Decoder and register file stand-in that issues requests
`timescale 1ns/100ps
module rdr_dec_model (
  // Clock and answer from the unit
  input wire logic clock,
  input wire logic busy,
  input wire logic res_valid,
  // Request
  output logic req_valid,
  output logic [2:0] req_op,
  output logic req_byte,
  output logic req_twice,
  output logic [15:0] req_dst,
  output logic [7:0] req_src,
  // Flags handed in with the request
  output logic req_carry,
  output logic req_zero,
  output logic req_sign,
  output logic req_ovf,
  output logic req_dec,
  output logic req_half
);
  initial {req_valid, req_op, req_byte, req_twice, req_dst, req_src, req_carry, req_zero, req_sign, req_ovf,
    req_dec, req_half} = '0;
  // Source and destination come from two distinct registers
  task automatic issue(input logic [2:0] op, input logic b, t, input logic [15:0] d, input logic [7:0] s,
    input logic [5:0] f, output logic ok);
    ok = 1'b0;
    // A busy unit drops requests silently, so wait it out first
    for (int n = 0; n < 8 && busy; n++) begin
      @(posedge clock);
    end
    {req_op, req_byte, req_twice, req_dst, req_src} <= {op, b, t, d, s};
    {req_carry, req_zero, req_sign, req_ovf, req_dec, req_half} <= f;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    // Operands held until the answer, bounded wait
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge clock);
      ok = res_valid;
    end
  endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the rotate unit
`timescale 1ns/100ps
module tb;
  logic clock, resetn, busy, res_valid, req_valid, req_byte, req_twice, req_carry, req_zero, req_sign, req_ovf;
  logic req_dec, req_half, res_carry, res_zero, res_sign, res_ovf, res_dec, res_half, ok;
  logic [2:0] req_op;
  logic [15:0] req_dst, res_dst;
  logic [7:0] req_src, res_src;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  rdr_unit #(.WORD_W(16)) dut (.clock, .resetn, .req_valid, .req_op, .req_byte, .req_twice, .req_dst, .req_src,
    .req_carry, .req_zero, .req_sign, .req_ovf, .req_dec, .req_half, .busy, .res_valid, .res_dst, .res_src,
    .res_carry, .res_zero, .res_sign, .res_ovf, .res_dec, .res_half);
  rdr_dec_model dec (.clock, .busy, .res_valid, .req_valid, .req_byte, .req_twice, .req_carry, .req_zero,
    .req_sign, .req_ovf, .req_dec, .req_half, .req_op, .req_dst, .req_src);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string nm, input logic [23:0] exp, got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One step: result word then carry
  function automatic logic [16:0] step(input logic [2:0] op, input logic b, input logic [15:0] d, input logic c);
    logic t, i;
    t = b ? d[7] : d[15];
    i = op == 3'h0 ? t : op == 3'h1 ? d[0] : c;
    if (!op[0]) return {b ? {d[15:8], d[6:0], i} : {d[14:0], i}, t};
    return {b ? {d[15:8], i, d[7:1]} : {i, d[15:1]}, d[0]};
  endfunction
  task automatic run(input logic [2:0] op, input logic b, t, input logic [15:0] d, input logic [7:0] s,
    input logic [5:0] f);
    logic [15:0] r;
    logic [7:0] q;
    logic c, v, m, w;
    {r, q, c, v} = {d, s, f[5], f[2]};
    w = b | op[2];
    if (op[2]) begin
      r[3:0] = op[0] ? s[3:0] : s[7:4];
      q = op[0] ? {d[3:0], s[7:4]} : {s[3:0], d[3:0]};
    end else for (int k = 0; k <= t; k++) begin
      m = b ? r[7] : r[15];
      {r, c} = step(op, b, r, c);
      v = m != (b ? r[7] : r[15]);
    end
    dec.issue(op, b, t, d, s, f, ok);
    check("res_valid", 24'h1, 24'(ok));
    check("res_dst", 24'(r), 24'(res_dst));
    check("res_src", 24'(q), 24'(res_src));
    check("flags", 24'({c, w ? r[7:0] == 0 : r == 0, w ? r[7] : r[15], v, f[1:0]}),
      24'({res_carry, res_zero, res_sign, res_ovf, res_dec, res_half}));
  endtask
  task automatic t_reset;
    check("reset data", 24'h0, {res_dst, res_src});
    check("reset flags", 24'h0, 24'({busy, res_valid, res_carry, res_zero, res_sign, res_ovf, res_dec, res_half}));
  endtask
  // Back to back, byte and word, once and twice
  task automatic t_bits;
    logic [15:0] v[4] = '{16'h7f88, 16'h0031, 16'h800f, 16'h0000};
    for (int o = 0; o < 4; o++) begin
      for (int i = 0; i < 8; i++) run(3'(o), i[0], i[1], v[(i + o) % 4], 8'h5a, {i[2], 3'h2, i[0], ~i[0]});
    end
  endtask
  task automatic t_digits;
    logic [23:0] v[3] = '{24'h5a12_34, 24'h1200_09, 24'h0080_56};
    for (int o = 4; o < 6; o++) begin
      for (int i = 0; i < 3; i++) run(3'(o), 1'b0, 1'b1, v[i][23:8], v[i][7:0], 6'h2f);
    end
  endtask
  // Unused op code gets no answer
  task automatic t_refused;
    dec.issue(3'h6, 1'b0, 1'b0, 16'h1234, 8'h56, 6'h0, ok);
    check("refused op", 24'h0, 24'({ok, busy}));
  endtask
  task automatic summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    resetn = 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    @(posedge clock);
    t_bits();
    t_digits();
    t_refused();
    summarize();
  end
endmodule
